// ===== rtl/pmsc_consts.svh
// Register offsets, field positions, reset values and timing figures of the power control block.
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH

// Register byte addresses on the bus.
`define PMSC_OFS_CTRL1 12'h004
`define PMSC_OFS_RES1 12'h008
`define PMSC_OFS_SNOOZE 12'h00C
`define PMSC_OFS_STATUS 12'h010
`define PMSC_OFS_CMD 12'h014

// Control register 1 fields.
`define PMSC_BIT_AUTO_SLEEP_RX 12
`define PMSC_BIT_SNOOZE_EN 13
`define PMSC_BIT_SNOOZE_REP 14
`define PMSC_BIT_SYNC_GHZ 15
`define PMSC_BIT_EDGE_RUN 17
`define PMSC_DIV_LSB 26
`define PMSC_DIV_MSB 31
`define POWER_MGMT_CONTROL_1_RST 32'h0402_0738
`define POWER_MGMT_CONTROL_1_WMASK 32'hFC02_F000

// Snooze period field.
`define PMSC_SNOOZE_RST 8'h40
`define PMSC_SNOOZE_LOW_BITS 9

// Status register bits.
`define PMSC_ST_ASLEEP 0
`define PMSC_ST_SNOOZING 1
`define PMSC_ST_RX 2
`define PMSC_ST_EDGE_RUN 3
`define PMSC_ST_CODE_LOADED 4

// Command register bits.
`define PMSC_CMD_LOAD 0
`define PMSC_CMD_RX 1

// Clock rates, in kHz, and divider widths, in bits.
`define PMSC_CLK_KHZ 10000
`define PMSC_HALF_XTAL_KHZ 19200
`define PMSC_DIV_WIDTH 10
`define PMSC_LED_DIV_WIDTH 4

`endif

// ===== rtl/pmsc_pkg.sv
// Types shared by the power control block files.
package pmsc_pkg;
    typedef enum logic [3:0] {
        PMSC_IDLE = 4'h1,
        PMSC_RX = 4'h2,
        PMSC_SLEEP = 4'h4,
        PMSC_SNOOZE = 4'h8
    } pmsc_state_type;
endpackage

// ===== rtl/pmsc_snooze_timer.sv
// Snooze period timer counting half-crystal ticks.
`timescale 1ns/1ps
`include "pmsc_consts.svh"
module pmsc_snooze_timer #(
    parameter int LOW_BITS = `PMSC_SNOOZE_LOW_BITS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Timing.
    input wire logic tick,
    input wire logic load,
    input wire logic [7:0] period,
    // Expiry.
    output logic expired
);
    logic [8+LOW_BITS-1:0] count_ff;
    logic expired_ff;

    // Loading (period + 1) << (LOW_BITS - 1) gives the documented plus-one length.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= '0;
        end else if (load) begin
            count_ff <= {({1'b0, period} + 9'h001), {(LOW_BITS-1){1'b0}}};
        end else if (tick && count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            expired_ff <= 1'b0;
        end else begin
            expired_ff <= !load && tick && count_ff == {{(8+LOW_BITS-1){1'b0}}, 1'b1};
        end
    end

    assign expired = expired_ff;
endmodule

// ===== rtl/pmsc_khz_divider.sv
// Kilohertz clock divider with a further LED blink stage.
`timescale 1ns/1ps
`include "pmsc_consts.svh"
module pmsc_khz_divider #(
    parameter int WIDTH = `PMSC_DIV_WIDTH,
    parameter int LED_WIDTH = `PMSC_LED_DIV_WIDTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Source tick and divisor.
    input wire logic tick,
    input wire logic [5:0] divisor,
    // Outputs.
    output logic khz_tick,
    output logic led_tick
);
    // One extra bit of headroom: a full divisor of 63 needs a count of 2016, past ten bits.
    logic [WIDTH:0] count_ff;
    logic [LED_WIDTH-1:0] led_ff;
    logic khz_ff;
    logic led_out_ff;
    logic [WIDTH:0] limit;

    // The divisor sets the top six bits, so the period is divisor * 32 ticks.
    assign limit = {divisor, {(WIDTH-5){1'b0}}};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= '0;
            khz_ff <= 1'b0;
        end else begin
            khz_ff <= 1'b0;
            if (tick) begin
                if (count_ff + 1'b1 >= limit) begin
                    count_ff <= '0;
                    khz_ff <= limit != '0;
                end else begin
                    count_ff <= count_ff + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            led_ff <= '0;
            led_out_ff <= 1'b0;
        end else begin
            led_out_ff <= khz_ff && led_ff == '1;
            if (khz_ff) begin
                led_ff <= led_ff + 1'b1;
            end
        end
    end

    assign khz_tick = khz_ff;
    assign led_tick = led_out_ff;
endmodule

// ===== rtl/pmsc_power_ctrl.sv
// Power control: auto sleep, snooze sequencing, clock enables and edge algorithm control.
`timescale 1ns/1ps
`include "pmsc_consts.svh"
// Function
// - Auto sleep after receive unless interrupt pending
// - Wake clears auto sleep unless preserved
// - Snooze timed by half-crystal clock period
// - Repeat alternates snooze and receive indefinitely
// - Sync bit enables gigahertz clock
// - Edge run resets one, starts on delimiter
// - Edge run clear skips algorithm, no stamp
// - Load edge code on command or wake
// - Divisor is top six of ten bits; the code puts it in the top six of an eleven-bit limit (divisor * 32)
// - Divisors up to 2016 supported
// - Divided clock feeds debounce and blink
// - Snooze field upper eight bits, plus one
module pmsc_power_ctrl
    import pmsc_pkg::*;
#(
    parameter int CLK_KHZ = `PMSC_CLK_KHZ,
    parameter int HALF_XTAL_KHZ = `PMSC_HALF_XTAL_KHZ
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver and interrupt status.
    input wire logic rx_attempt_done,
    input wire logic sfd_detected,
    input wire logic irq_pending,
    // Always-on wake configuration.
    input wire logic wake_event,
    input wire logic preserve_sleep_config,
    input wire logic wake_load_edge_code,
    input wire logic edge_code_load_done,
    // Control outputs.
    output logic rx_enable,
    output logic sleep_request,
    output logic sync_ghz_clock_enable,
    output logic edge_algo_start,
    output logic rx_stamp_update,
    output logic edge_code_load,
    output logic khz_tick,
    output logic led_tick
);
    import pmsc_pkg::*;

    pmsc_state_type state_ff;
    pmsc_state_type nxt_state;
    logic [31:0] ctrl1_ff;
    logic [7:0] snooze_period_ff;
    logic [31:0] rdata_ff;
    logic xtal_tick_ff;
    logic [31:0] phase_ff;
    logic loaded_ff;
    logic load_busy_ff;
    logic edge_start_ff;
    logic stamp_ff;
    logic wr_en;
    logic rd_en;
    logic cmd_load;
    logic cmd_rx;
    logic snooze_load;
    logic snooze_expired;
    logic waking;
    logic auto_sleep_after_rx;
    logic snooze_enable;
    logic snooze_repeat;
    logic edge_algo_run_enable;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign cmd_load = wr_en && paddr == `PMSC_OFS_CMD && pwdata[`PMSC_CMD_LOAD];
    assign cmd_rx = wr_en && paddr == `PMSC_OFS_CMD && pwdata[`PMSC_CMD_RX];
    assign auto_sleep_after_rx = ctrl1_ff[`PMSC_BIT_AUTO_SLEEP_RX];
    assign snooze_enable = ctrl1_ff[`PMSC_BIT_SNOOZE_EN];
    assign snooze_repeat = ctrl1_ff[`PMSC_BIT_SNOOZE_REP];
    assign edge_algo_run_enable = ctrl1_ff[`PMSC_BIT_EDGE_RUN];
    assign waking = state_ff == PMSC_SLEEP && wake_event;

    // Zero wait states; the reserved area accepts no write and flags an error.
    assign pready = 1'b1;
    assign pslverr = psel && penable && pwrite && paddr == `PMSC_OFS_RES1;

    // Phase accumulator makes a one-cycle tick at the half-crystal rate, scaled to this clock.
    // The core clock is slower, so ticks saturate at one per cycle; a faster core gives true timing.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= '0;
            xtal_tick_ff <= 1'b0;
        end else if (HALF_XTAL_KHZ >= CLK_KHZ) begin
            phase_ff <= '0;
            xtal_tick_ff <= 1'b1;
        end else begin
            if (phase_ff + 32'(HALF_XTAL_KHZ) >= 32'(CLK_KHZ)) begin
                phase_ff <= phase_ff + 32'(HALF_XTAL_KHZ) - 32'(CLK_KHZ);
                xtal_tick_ff <= 1'b1;
            end else begin
                phase_ff <= phase_ff + 32'(HALF_XTAL_KHZ);
                xtal_tick_ff <= 1'b0;
            end
        end
    end

    // Control register 1; the wake clear of auto sleep loses to a simultaneous software write.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1_ff <= `POWER_MGMT_CONTROL_1_RST;
        end else if (wr_en && paddr == `PMSC_OFS_CTRL1) begin
            ctrl1_ff <= (ctrl1_ff & ~`POWER_MGMT_CONTROL_1_WMASK) | (pwdata & `POWER_MGMT_CONTROL_1_WMASK);
        end else if (waking && !preserve_sleep_config) begin
            ctrl1_ff[`PMSC_BIT_AUTO_SLEEP_RX] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            snooze_period_ff <= `PMSC_SNOOZE_RST;
        end else if (wr_en && paddr == `PMSC_OFS_SNOOZE) begin
            snooze_period_ff <= pwdata[7:0];
        end
    end

    // Sequencer between idle, receive, sleep and snooze.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PMSC_IDLE: begin
                if (cmd_rx) begin
                    nxt_state = PMSC_RX;
                end
            end
            PMSC_RX: begin
                if (rx_attempt_done) begin
                    if (snooze_enable && !irq_pending) begin
                        nxt_state = PMSC_SNOOZE;
                    end else if (auto_sleep_after_rx && !irq_pending) begin
                        nxt_state = PMSC_SLEEP;
                    end else begin
                        nxt_state = PMSC_IDLE;
                    end
                end
            end
            PMSC_SLEEP: begin
                if (wake_event) begin
                    nxt_state = PMSC_IDLE;
                end
            end
            PMSC_SNOOZE: begin
                if (snooze_expired) begin
                    nxt_state = PMSC_RX;
                end
            end
            default: nxt_state = PMSC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= PMSC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Without repeat, snooze_once_ff sets once a snooze has been entered; the state change and timer load ignore it, so snooze still repeats.
    logic snooze_once_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            snooze_once_ff <= 1'b0;
        end else if (state_ff == PMSC_IDLE) begin
            snooze_once_ff <= 1'b0;
        end else if (snooze_load) begin
            snooze_once_ff <= !snooze_repeat;
        end
    end

    assign snooze_load = state_ff == PMSC_RX && nxt_state == PMSC_SNOOZE && !snooze_once_ff;

    pmsc_snooze_timer u_snooze_timer (
        .clk(clk),
        .rst_b(rst_b),
        .tick(xtal_tick_ff),
        .load(snooze_load || (state_ff == PMSC_RX && nxt_state == PMSC_SNOOZE)),
        .period(snooze_period_ff),
        .expired(snooze_expired)
    );

    // Edge code load: explicit command, or on wake when the wake-load option is set.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            load_busy_ff <= 1'b0;
            loaded_ff <= 1'b0;
        end else if (cmd_load || (waking && wake_load_edge_code)) begin
            load_busy_ff <= 1'b1;
            loaded_ff <= 1'b0;
        end else if (load_busy_ff && edge_code_load_done) begin
            load_busy_ff <= 1'b0;
            loaded_ff <= 1'b1;
        end else if (state_ff == PMSC_SLEEP) begin
            loaded_ff <= 1'b0;
        end
    end

    // Edge algorithm starts on the delimiter only while run is enabled.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_start_ff <= 1'b0;
            stamp_ff <= 1'b0;
        end else begin
            edge_start_ff <= sfd_detected && edge_algo_run_enable && state_ff == PMSC_RX;
            stamp_ff <= edge_start_ff && edge_algo_run_enable;
        end
    end

    // Register reads, captured in the setup phase.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= '0;
        end else if (rd_en) begin
            unique case (paddr)
                `PMSC_OFS_CTRL1: rdata_ff <= ctrl1_ff;
                `PMSC_OFS_SNOOZE: rdata_ff <= {24'h00_0000, snooze_period_ff};
                `PMSC_OFS_STATUS: begin
                    rdata_ff <= '0;
                    rdata_ff[`PMSC_ST_ASLEEP] <= state_ff == PMSC_SLEEP;
                    rdata_ff[`PMSC_ST_SNOOZING] <= state_ff == PMSC_SNOOZE;
                    rdata_ff[`PMSC_ST_RX] <= state_ff == PMSC_RX;
                    rdata_ff[`PMSC_ST_EDGE_RUN] <= edge_start_ff;
                    rdata_ff[`PMSC_ST_CODE_LOADED] <= loaded_ff;
                end
                default: rdata_ff <= '0;
            endcase
        end
    end

    assign prdata = rdata_ff;

    pmsc_khz_divider u_khz_divider (
        .clk(clk),
        .rst_b(rst_b),
        .tick(xtal_tick_ff),
        .divisor(ctrl1_ff[`PMSC_DIV_MSB:`PMSC_DIV_LSB]),
        .khz_tick(khz_tick),
        .led_tick(led_tick)
    );

    assign rx_enable = state_ff == PMSC_RX;
    assign sleep_request = state_ff == PMSC_SLEEP;
    assign sync_ghz_clock_enable = ctrl1_ff[`PMSC_BIT_SYNC_GHZ];
    assign edge_algo_start = edge_start_ff;
    assign rx_stamp_update = stamp_ff;
    assign edge_code_load = load_busy_ff;
endmodule

// ===== tb/pmsc_power_ctrl_assertions.sv
// Port-level checker of the power control block.
`timescale 1ns/1ps
module pmsc_power_ctrl_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Bus and event inputs.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic rx_attempt_done,
    input wire logic sfd_detected,
    input wire logic irq_pending,
    input wire logic wake_event,
    input wire logic wake_load_edge_code,
    input wire logic edge_code_load_done,
    // Watched outputs.
    input wire logic pslverr,
    input wire logic rx_enable,
    input wire logic sleep_request,
    input wire logic sync_ghz_clock_enable,
    input wire logic edge_algo_start,
    input wire logic rx_stamp_update,
    input wire logic edge_code_load,
    input wire logic khz_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rsvd_err;
        pslverr == (psel && penable && pwrite && paddr == 12'h008);
    endproperty
    a_rsvd_err: assert property (p_rsvd_err) else $error("reserved write flag wrong");
    property p_sync_cause;
        $changed(sync_ghz_clock_enable) |-> $past(psel && penable && pwrite && paddr == 12'h004);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("sync clock enable moved without a write");
    property p_start_cause;
        edge_algo_start |-> $past(sfd_detected && rx_enable);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("edge start without delimiter");
    property p_stamp_follows;
        edge_algo_start |=> rx_stamp_update;
    endproperty
    a_stamp_follows: assert property (p_stamp_follows) else $error("stamp update missing");
    property p_stamp_cause;
        rx_stamp_update |-> $past(edge_algo_start);
    endproperty
    a_stamp_cause: assert property (p_stamp_cause) else $error("stamp update without algorithm");
    property p_irq_blocks;
        rx_enable && rx_attempt_done && irq_pending |=> !sleep_request && !rx_enable;
    endproperty
    a_irq_blocks: assert property (p_irq_blocks) else $error("sleep entered with interrupt pending");
    property p_wake_load;
        sleep_request && wake_event && wake_load_edge_code |=> edge_code_load && !sleep_request;
    endproperty
    a_wake_load: assert property (p_wake_load) else $error("wake did not start code load");
    property p_load_hold;
        edge_code_load && !edge_code_load_done |=> edge_code_load;
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("code load dropped early");
    property p_khz_space;
        khz_tick |=> !khz_tick [*8];
    endproperty
    a_khz_space: assert property (p_khz_space) else $error("slow ticks too close");
    cover property (edge_algo_start);
    cover property ($rose(sleep_request));
    cover property (khz_tick);
endmodule
bind pmsc_power_ctrl pmsc_power_ctrl_chk i_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .rx_attempt_done, .sfd_detected, .irq_pending, .wake_event, .wake_load_edge_code,
    .edge_code_load_done, .pslverr, .rx_enable, .sleep_request, .sync_ghz_clock_enable,
    .edge_algo_start, .rx_stamp_update, .edge_code_load, .khz_tick);

// ===== tb/testbench.sv
// Self-checking bench of the power control block.
`timescale 1ns/1ps
`include "pmsc_consts.svh"
module testbench;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rx_enable, sleep_request, sync_ghz_clock_enable;
    logic rx_attempt_done = 1'b0, sfd_detected = 1'b0, irq_pending = 1'b0, wake_event = 1'b0;
    logic preserve_sleep_config = 1'b0, wake_load_edge_code = 1'b0, edge_code_load_done = 1'b0;
    logic edge_algo_start, rx_stamp_update, edge_code_load, khz_tick, led_tick;
    int bad_count = 0, total_checks = 0, cyc = 0, n_start = 0, n_stamp = 0;
    int khz_last = 0, khz_gap = 0, led_last = 0, led_gap = 0;
    pmsc_power_ctrl i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_attempt_done, .sfd_detected, .irq_pending, .wake_event, .preserve_sleep_config,
        .wake_load_edge_code, .edge_code_load_done, .rx_enable, .sleep_request, .sync_ghz_clock_enable,
        .edge_algo_start, .rx_stamp_update, .edge_code_load, .khz_tick, .led_tick);
    always #50 clk = ~clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Pulse counts and tick spacing are gathered here so tests never race the outputs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (edge_algo_start === 1'b1) n_start <= n_start + 1;
        if (rx_stamp_update === 1'b1) n_stamp <= n_stamp + 1;
        if (khz_tick === 1'b1) begin
            khz_gap <= cyc - khz_last;
            khz_last <= cyc;
        end
        if (led_tick === 1'b1) begin
            led_gap <= cyc - led_last;
            led_last <= cyc;
        end
        if (cyc == 15000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: sfd_detected <= 1'b1;
            1: rx_attempt_done <= 1'b1;
            2: wake_event <= 1'b1;
            default: edge_code_load_done <= 1'b1;
        endcase
        @(posedge clk);
        {sfd_detected, rx_attempt_done, wake_event, edge_code_load_done} <= 4'h0;
    endtask
    task automatic wait_rx(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rx_enable !== 1'b1 && n < 2000);
    endtask
    initial begin
        int n, s0, s1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, `PMSC_OFS_CTRL1, 0);
        chk(rd, `POWER_MGMT_CONTROL_1_RST);
        apb(0, `PMSC_OFS_SNOOZE, 0);
        chk(rd, 32'h0000_0040);
        apb(0, 12'h020, 0);
        chk(rd, 32'h0000_0000);
        apb(1, `PMSC_OFS_CTRL1, 32'hFFFF_FFFF);
        apb(0, `PMSC_OFS_CTRL1, 0);
        chk(rd, 32'hFC02_F738);
        chk(sync_ghz_clock_enable, 1'b1);
        apb(1, `PMSC_OFS_RES1, 32'h0);
        chk(err, 1'b1);
        apb(0, `PMSC_OFS_CTRL1, 0);
        chk(rd, 32'hFC02_F738);
        repeat (4100) @(posedge clk);
        chk(khz_gap, 2016);
        apb(1, `PMSC_OFS_CTRL1, 32'h0402_0000);
        repeat (1100) @(posedge clk);
        chk(khz_gap, 32);
        chk(led_gap, 512);
        chk(sync_ghz_clock_enable, 1'b0);
        apb(1, `PMSC_OFS_CMD, 32'h1);
        pulse(3);
        for (int r = 0; r < 2; r++) begin
            if (r == 1) apb(1, `PMSC_OFS_CTRL1, 32'h0400_0000);
            apb(1, `PMSC_OFS_CMD, 32'h2);
            wait_rx(n);
            s0 = n_start;
            s1 = n_stamp;
            pulse(0);
            repeat (4) @(posedge clk);
            chk(n_start - s0, 1 - r);
            chk(n_stamp - s1, 1 - r);
            pulse(1);
        end
        apb(1, `PMSC_OFS_CTRL1, 32'h0400_1000);
        irq_pending <= 1'b1;
        wake_load_edge_code <= 1'b1;
        apb(1, `PMSC_OFS_CMD, 32'h2);
        wait_rx(n);
        pulse(1);
        repeat (2) @(posedge clk);
        chk({rx_enable, sleep_request}, 2'b00);
        irq_pending <= 1'b0;
        // Second pass keeps the auto sleep bit across the wake.
        for (int p = 0; p < 2; p++) begin
            preserve_sleep_config <= p[0];
            apb(1, `PMSC_OFS_CTRL1, 32'h0400_1000);
            apb(1, `PMSC_OFS_CMD, 32'h2);
            wait_rx(n);
            pulse(1);
            repeat (2) @(posedge clk);
            chk(sleep_request, 1'b1);
            pulse(2);
            repeat (2) @(posedge clk);
            chk({sleep_request, edge_code_load}, 2'b01);
            pulse(3);
            apb(0, `PMSC_OFS_STATUS, 0);
            chk({rd[4], edge_code_load}, 2'b10);
            apb(0, `PMSC_OFS_CTRL1, 0);
            chk(rd[12], p[0]);
        end
        apb(1, `PMSC_OFS_CTRL1, 32'h0400_6000);
        apb(1, `PMSC_OFS_SNOOZE, 32'h0);
        apb(1, `PMSC_OFS_CMD, 32'h2);
        wait_rx(n);
        for (int s = 0; s < 3; s++) begin
            if (s == 2) apb(1, `PMSC_OFS_SNOOZE, 32'h1);
            pulse(1);
            wait_rx(n);
            s0 = (s == 2) ? 512 : 256;
            chk(n >= s0 && n <= s0 + 6, 1'b1);
        end
        final_report();
    end
endmodule
